// *** wdpd_consts.svh ***
`ifndef WDPD_CONSTS_SVH
`define WDPD_CONSTS_SVH

// I/O decode: base ports step by 80h from 220h, register at base plus 3.
`define WDPD_IO_BASE_FIRST    10'h220
`define WDPD_IO_BASE_STEP     10'h080
`define WDPD_FACTOR_OFFSET    2'h3
`define WDPD_FIXED_PORT_A     10'h076
`define WDPD_FIXED_PORT_B     10'h077

// Memory window: 16KB at CC00:0 stepping by 16KB, upper 8KB is the bank.
`define WDPD_WIN_BASE_FIRST   20'hcc000
`define WDPD_WIN_STEP         20'h04000
`define WDPD_WIN_HALF         20'h02000

// Factor codes.
`define WDPD_FACTOR_OFF       8'h00
`define WDPD_FACTOR_MIN       8'h80
`define WDPD_FACTOR_MAX       8'h87

// Time-out table: code 80h gives 3 s, code 8xh gives 6 s times x.
`define WDPD_FIRST_SEC        3
`define WDPD_STEP_SEC         6

// Timebase.
`define WDPD_CLK_PERIOD_NS    10
`define WDPD_TICK_MS          100
`define WDPD_TICK_CYCLES      ((`WDPD_TICK_MS * 1000000) / `WDPD_CLK_PERIOD_NS)
`define WDPD_TICKS_PER_SEC    (1000 / `WDPD_TICK_MS)
`define WDPD_PULSE_US         10
`define WDPD_PULSE_CYCLES     ((`WDPD_PULSE_US * 1000) / `WDPD_CLK_PERIOD_NS)
`define WDPD_BLINK_TICKS      5

`endif

// *** wdpd_pkg.sv ***
`default_nettype none
package wdpd_pkg;

  typedef struct packed {
    logic       wr;
    logic [9:0] addr;
    logic [7:0] data;
  } wdpd_io_req_t;

  typedef struct packed {
    logic       disk_hit;
    logic [1:0] disk_index;
    logic       wd_hit;
    logic       fw_hit;
    logic       bank_hit;
  } wdpd_decode_t;

  typedef enum logic [1:0] {
    WDPD_IDLE,
    WDPD_ARMED,
    WDPD_FIRING
  } wdpd_state_t;

endpackage
`default_nettype wire

// *** wdpd_watchdog.sv ***
// Overview of operation
// - Factor register at base+3, plus 76h/77h low bases.
// - Two switches pick base 220h/2A0h/320h/3A0h.
// - Four ports: three disk, fourth watchdog.
// - Factor 84h enables a 24 second time-out.
// - New factor accepted except during the reset pulse, new period applies.
// - Writing 00h disables the timer.
// - Reset output drives host reset header.
// - 16KB window: firmware low, bank high.
// - Two switches place window CC00/D000/D400/D800.
// - Factors 80h-87h map 3 to 42 seconds.
// - Watchdog disabled after every system reset.
// - Factor write clears count; expiry emits reset.
// - LED blinks while the watchdog counts.
`timescale 1ns/100ps
`include "wdpd_consts.svh"
`default_nettype none
module wdpd_watchdog
  import wdpd_pkg::*;
#(
  parameter int TICK_CYCLES  = `WDPD_TICK_CYCLES,
  parameter int PULSE_CYCLES = `WDPD_PULSE_CYCLES
) (
  input  wire logic         clk_sys,
  input  wire logic         rst_n,
  input  wire wdpd_io_req_t io_req,
  input  wire logic [19:0]  mem_addr,
  input  wire logic         base_select_low,
  input  wire logic         base_select_high,
  input  wire logic         window_select_low,
  input  wire logic         window_select_high,
  output wdpd_decode_t      decode,
  output logic              reset_output_header,
  output logic              activity_led_header,
  output logic              wd_armed
);

  localparam int NFACT = 8;

  wdpd_state_t  state_reg, state_next;
  logic [31:0]  presc_reg, presc_next;
  logic [15:0]  cnt_reg, cnt_next;
  logic [15:0]  limit_reg, limit_next;
  logic [15:0]  pulse_reg, pulse_next;
  logic [3:0]   blink_reg, blink_next;
  logic         led_reg, led_next;
  logic         rst_out_reg, rst_out_next;
  logic [9:0]   io_base;
  logic [19:0]  win_base;
  logic         fixed_port;
  logic         wr_factor, factor_valid, factor_off, tick;
  logic [15:0]  limit_tbl [NFACT];

  // Time-out lengths in ticks, one entry per factor code.
  genvar gi;
  generate
    for (gi = 0; gi < NFACT; gi++) begin : g_tbl
      localparam int SEC = (gi == 0) ? `WDPD_FIRST_SEC
                                     : `WDPD_STEP_SEC * gi;
      assign limit_tbl[gi] = 16'(SEC * `WDPD_TICKS_PER_SEC);
    end
  endgenerate

  always_comb begin
    io_base  = `WDPD_IO_BASE_FIRST
             + 10'({base_select_high, base_select_low})
             * `WDPD_IO_BASE_STEP;
    win_base = `WDPD_WIN_BASE_FIRST
             + 20'({window_select_high, window_select_low})
             * `WDPD_WIN_STEP;
    // The two low bases also answer at 76h and 77h.
    fixed_port = !base_select_high
               && (io_req.addr == `WDPD_FIXED_PORT_A
                   || io_req.addr == `WDPD_FIXED_PORT_B);
    decode.disk_index = io_req.addr[1:0];
    decode.disk_hit   = io_req.addr[9:2] == io_base[9:2]
                      && io_req.addr[1:0] != `WDPD_FACTOR_OFFSET;
    decode.wd_hit     = (io_req.addr[9:2] == io_base[9:2]
                         && io_req.addr[1:0] == `WDPD_FACTOR_OFFSET)
                      || fixed_port;
    decode.fw_hit     = mem_addr[19:14] == win_base[19:14]
                      && !mem_addr[13];
    decode.bank_hit   = mem_addr[19:14] == win_base[19:14]
                      && mem_addr[13];
  end

  always_comb begin
    wr_factor    = io_req.wr && decode.wd_hit;
    factor_valid = io_req.data >= `WDPD_FACTOR_MIN
                && io_req.data <= `WDPD_FACTOR_MAX;
    factor_off   = io_req.data == `WDPD_FACTOR_OFF;
    tick         = presc_reg == 32'(TICK_CYCLES - 1);
    state_next   = state_reg;
    presc_next   = tick ? 32'h0 : presc_reg + 32'h1;
    cnt_next     = cnt_reg;
    limit_next   = limit_reg;
    pulse_next   = pulse_reg;
    blink_next   = blink_reg;
    led_next     = 1'b0;
    rst_out_next = 1'b0;
    unique case (state_reg)
      WDPD_IDLE, WDPD_ARMED: begin
        if (state_reg == WDPD_ARMED && tick) begin
          if (cnt_reg == limit_reg - 16'h1) begin
            state_next   = WDPD_FIRING;
            pulse_next   = 16'h0;
            rst_out_next = 1'b1;
          end else begin
            cnt_next = cnt_reg + 16'h1;
          end
          blink_next = (blink_reg == 4'(`WDPD_BLINK_TICKS - 1))
                     ? 4'h0 : blink_reg + 4'h1;
        end
        // A write in the same cycle as expiry wins: the host did re-arm.
        if (wr_factor && factor_valid) begin
          state_next   = WDPD_ARMED;
          limit_next   = limit_tbl[io_req.data[2:0]];
          cnt_next     = 16'h0;
          presc_next   = 32'h0;
          rst_out_next = 1'b0;
        end else if (wr_factor && factor_off) begin
          state_next   = WDPD_IDLE;
          rst_out_next = 1'b0;
        end
        if (state_next == WDPD_ARMED) begin
          led_next = (tick && blink_reg == 4'(`WDPD_BLINK_TICKS - 1))
                   ? !led_reg : led_reg;
        end
      end
      WDPD_FIRING: begin
        // Writes are ignored until the pulse is complete.
        rst_out_next = 1'b1;
        pulse_next   = pulse_reg + 16'h1;
        if (pulse_reg == 16'(PULSE_CYCLES - 1)) begin
          state_next   = WDPD_IDLE;
          rst_out_next = 1'b0;
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      state_reg   <= WDPD_IDLE;
      presc_reg   <= 32'h0;
      cnt_reg     <= 16'h0;
      limit_reg   <= 16'h0;
      pulse_reg   <= 16'h0;
      blink_reg   <= 4'h0;
      led_reg     <= 1'b0;
      rst_out_reg <= 1'b0;
    end else begin
      state_reg   <= state_next;
      presc_reg   <= presc_next;
      cnt_reg     <= cnt_next;
      limit_reg   <= limit_next;
      pulse_reg   <= pulse_next;
      blink_reg   <= blink_next;
      led_reg     <= led_next;
      rst_out_reg <= rst_out_next;
    end
  end

  assign reset_output_header = rst_out_reg;
  assign activity_led_header = led_reg;
  assign wd_armed            = state_reg == WDPD_ARMED;

  // Checking logic.
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  logic [15:0] high_len;
  always_ff @(posedge clk_sys) begin
    if (!rst_n) high_len <= 16'h0;
    else if (rst_out_reg) high_len <= high_len + 16'h1;
    else high_len <= 16'h0;
  end

  a_arm_clears: assert property (
    wr_factor && factor_valid && state_reg != WDPD_FIRING
    |=> state_reg == WDPD_ARMED && cnt_reg == 16'h0)
    else $error("factor write did not arm and clear");
  a_period_pick: assert property (
    wr_factor && io_req.data == 8'h84 && state_reg != WDPD_FIRING
    |=> limit_reg == 16'(24 * `WDPD_TICKS_PER_SEC))
    else $error("factor 84h did not select 24 seconds");
  a_disable_write: assert property (
    wr_factor && factor_off && state_reg != WDPD_FIRING
    |=> state_reg == WDPD_IDLE ##1 !reset_output_header)
    else $error("zero write did not disable");
  a_bad_ignored: assert property (
    wr_factor && !factor_valid && !factor_off
    && state_reg == WDPD_IDLE && !tick
    |=> state_reg == WDPD_IDLE && $stable(limit_reg))
    else $error("invalid factor changed the timer");
  a_fire_cause: assert property (
    $rose(reset_output_header)
    |-> $past(cnt_reg) == $past(limit_reg) - 16'h1 && $past(tick))
    else $error("reset fired before the time-out");
  // A system reset in mid-pulse also drops the output, so it is excluded.
  a_pulse_len: assert property (
    $fell(reset_output_header) && $past(rst_n)
    |-> high_len == 16'(PULSE_CYCLES))
    else $error("reset pulse length wrong");
  a_base_port: assert property (
    io_req.addr == io_base + 10'h3 |-> decode.wd_hit && !decode.disk_hit)
    else $error("base plus three not decoded");
  a_fixed_port: assert property (
    io_req.addr == `WDPD_FIXED_PORT_B |-> decode.wd_hit == !base_select_high)
    else $error("fixed port decode wrong");
  a_window_pos: assert property (
    decode.fw_hit |-> mem_addr >= win_base
                   && mem_addr < win_base + `WDPD_WIN_HALF)
    else $error("firmware window misplaced");
  a_led_armed: assert property (
    activity_led_header |-> state_reg == WDPD_ARMED)
    else $error("LED lit while not counting");
  a_reset_idle: assert property (@(posedge clk_sys) disable iff (1'b0)
    !rst_n |=> state_reg == WDPD_IDLE && !reset_output_header
               && !activity_led_header)
    else $error("watchdog not idle after reset");

  c_arm:    cover property (wr_factor && factor_valid);
  c_fire:   cover property ($rose(reset_output_header));
  c_rearm:  cover property (wr_factor && factor_valid && wd_armed);
  c_disarm: cover property (wr_factor && factor_off && wd_armed);

endmodule
`default_nettype wire

// *** wdpd_host.sv ***
`timescale 1ns/100ps
`default_nettype none
module wdpd_host
  import wdpd_pkg::*;
(
  input  wire logic        clk_sys,
  output var wdpd_io_req_t io_req
);
  initial io_req = '0;

  // Address moves and data is zeroed with write held low, so decode can be observed without a write.
  task automatic look(input logic [9:0] a);
    io_req <= '{wr: 1'b0, addr: a, data: 8'h00};
  endtask

  // Released lines show inverted values so stale data is never trusted.
  task automatic put(input logic [9:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    io_req <= '{wr: 1'b1, addr: a, data: d};
    @(posedge clk_sys);
    io_req <= '{wr: 1'b0, addr: ~a, data: ~d};
  endtask
endmodule
`default_nettype wire

// *** watchdog_port_decode_bench.sv ***
`timescale 1ns/100ps
`default_nettype none
module watchdog_port_decode_bench;
  import wdpd_pkg::*;
  logic         clk_sys = 1'b0;
  logic         rst_n = 1'b0;
  logic [19:0]  mem_addr = 20'h00000;
  logic [3:0]   sw = 4'h0;
  logic         led_seen = 1'b0;
  wdpd_io_req_t io_req;
  wdpd_decode_t decode;
  logic         reset_output_header;
  logic         activity_led_header;
  logic         wd_armed;
  int           errors = 0;
  int           comparisons = 0;
  logic [37:0]  rows [9] = '{
    {4'h0, 10'h223, 20'hcc000, 4'h6}, {4'h0, 10'h076, 20'hce000, 4'h5},
    {4'h4, 10'h077, 20'hcbfff, 4'h4}, {4'h4, 10'h2a2, 20'hd0000, 4'h8},
    {4'h8, 10'h076, 20'hd0000, 4'h0}, {4'h9, 10'h323, 20'hd2000, 4'h5},
    {4'he, 10'h3a3, 20'hd4000, 4'h6}, {4'hf, 10'h077, 20'hda000, 4'h1},
    {4'h3, 10'h224, 20'hdbfff, 4'h1}};

  always #5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) if (activity_led_header === 1'b1) led_seen <= 1'b1;

  wdpd_host i_wdpd_host (.clk_sys(clk_sys), .io_req(io_req));

  wdpd_watchdog #(.TICK_CYCLES(4), .PULSE_CYCLES(4)) i_wdpd_watchdog (
    .clk_sys(clk_sys), .rst_n(rst_n), .io_req(io_req), .mem_addr(mem_addr),
    .base_select_low(sw[2]), .base_select_high(sw[3]),
    .window_select_low(sw[0]), .window_select_high(sw[1]),
    .decode(decode), .reset_output_header(reset_output_header),
    .activity_led_header(activity_led_header), .wd_armed(wd_armed));

  task automatic tally_and_finish();
    $display("errors=%0d comparisons=%0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic ok, input string msg);
    comparisons++;
    if (ok !== 1'b1) begin
      errors++;
      $display("[FAIL] %0t %s", $time, msg);
    end
  endtask

  task automatic fire(input int lim);
    int n;
    n = 0;
    while (reset_output_header !== 1'b1 && n < 2000) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    chk(n >= lim * 4 - 2 && n <= lim * 4 + 2, "expiry time");
    if (n >= 2000) tally_and_finish();
    n = 0;
    while (reset_output_header === 1'b1 && n < 20) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    chk(n == 4 && wd_armed === 1'b0, "pulse length");
    if (n >= 20) tally_and_finish();
  endtask

  initial begin
    int q;
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    #1;
    chk(reset_output_header === 1'b0 && wd_armed === 1'b0
        && activity_led_header === 1'b0, "reset");
    foreach (rows[i]) begin
      @(posedge clk_sys);
      sw <= rows[i][37:34];
      mem_addr <= rows[i][23:4];
      i_wdpd_host.look(rows[i][33:24]);
      #1;
      chk({decode.disk_hit, decode.wd_hit, decode.fw_hit, decode.bank_hit}
          === rows[i][3:0], "decode row");
      chk(decode.disk_index === rows[i][25:24], "disk index");
    end
    @(posedge clk_sys);
    sw <= 4'h0;
    i_wdpd_host.put(10'h223, 8'h55);
    i_wdpd_host.put(10'h223, 8'h88);
    #1;
    chk(wd_armed === 1'b0, "bad factor taken");
    i_wdpd_host.put(10'h077, 8'h80);
    #1;
    chk(wd_armed === 1'b1, "not armed");
    fire(30);
    chk(led_seen === 1'b1 && activity_led_header === 1'b0, "led");
    i_wdpd_host.put(10'h223, 8'h80);
    repeat (100) @(posedge clk_sys);
    i_wdpd_host.put(10'h223, 8'h80);
    fire(30);
    i_wdpd_host.put(10'h223, 8'h87);
    i_wdpd_host.put(10'h223, 8'h81);
    fire(60);
    i_wdpd_host.put(10'h076, 8'h84);
    fire(240);
    i_wdpd_host.put(10'h223, 8'h84);
    i_wdpd_host.put(10'h223, 8'h00);
    q = 0;
    repeat (1100) begin
      @(posedge clk_sys);
      #1;
      if (reset_output_header !== 1'b0) q++;
    end
    chk(q == 0 && wd_armed === 1'b0, "disable");
    i_wdpd_host.put(10'h223, 8'h83);
    @(posedge clk_sys);
    rst_n <= 1'b0;
    @(posedge clk_sys);
    rst_n <= 1'b1;
    #1;
    chk(wd_armed === 1'b0 && reset_output_header === 1'b0, "rerst");
    tally_and_finish();
  end
endmodule
`default_nettype wire
